// *** inc/pgfi_regs.vh ***
`ifndef PGFI_REGS_VH
`define PGFI_REGS_VH

// Register offsets
`define PGFI_ADDR_PG_CTRL_A 8'h15
`define PGFI_ADDR_PG_CTRL_B 8'h16
`define PGFI_ADDR_FAULT_LATCH 8'h17
`define PGFI_ADDR_SOFT_RESET 8'h18
`define PGFI_ADDR_TOP_FLAGS 8'h19
`define PGFI_ADDR_TOP_FLAGS_B 8'h1a
`define PGFI_ADDR_BUCK_EVENTS 8'h1b
`define PGFI_ADDR_LDO_EVENTS 8'h1c
`define PGFI_ADDR_TOP_STATUS 8'h1d

// Reset values
`define PGFI_RST_PG_CTRL_A 8'h0f
`define PGFI_RST_PG_CTRL_B 8'h00
`define PGFI_RST_FAULT_LATCH 4'h0
`define PGFI_RST_TOP_FLAGS 8'h00

// Control A fields
`define PGFI_BIT_POLARITY 7
`define PGFI_MON_EN_MSB 3
`define PGFI_MON_EN_LSB 0

// Control B fields
`define PGFI_BIT_TWARN_GATES 2
`define PGFI_BIT_FAULT_DRIVES 1
`define PGFI_BIT_MODE 0

// Soft reset field
`define PGFI_BIT_SOFT_RESET 0

// Top flag fields
`define PGFI_BIT_PG_DROP 7
`define PGFI_BIT_LDO_SUM 6
`define PGFI_BIT_BUCK_SUM 5
`define PGFI_BIT_EXT_CLK 4
`define PGFI_BIT_TSD 3
`define PGFI_BIT_TWARN 2
`define PGFI_BIT_OVP 1
`define PGFI_BIT_CUR_RES 0

// Second top flag field
`define PGFI_BIT_RESET_SEEN 0

// Synchroniser depth for pins
`define PGFI_SYNC_STAGES 3

`endif

// *** core/pgfi_sync.v ***
`timescale 1ns/1ps
// Three-stage pin synchroniser; output moves only when stages two and three agree
module pgfi_sync #(
  parameter W = 1
) (
  // Clock and reset
  input wire sys_clk,
  input wire reset_n,
  // Pins and clean levels
  input wire [W-1:0] pin_in,
  output wire [W-1:0] level_out
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg s1_ff;
      reg s2_ff;
      reg s3_ff;
      reg lvl_ff;
      always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          s1_ff <= 1'b0;
          s2_ff <= 1'b0;
          s3_ff <= 1'b0;
          lvl_ff <= 1'b0;
        end else begin
          s1_ff <= pin_in[i];
          s2_ff <= s1_ff;
          s3_ff <= s2_ff;
          if (s2_ff == s3_ff) begin
            lvl_ff <= s3_ff;
          end
        end
      end
      assign level_out[i] = lvl_ff;
    end
  endgenerate
endmodule // pgfi_sync

// *** core/pgfi_w1c.v ***
`timescale 1ns/1ps
// Bank of sticky flags: hardware sets, software clears, set wins on collision
module pgfi_w1c #(
  parameter W = 8
) (
  // Clock and reset
  input wire sys_clk,
  input wire reset_n,
  // Control
  input wire restore,
  input wire [W-1:0] set_in,
  input wire [W-1:0] clr_in,
  // State
  output wire [W-1:0] flags
);
  reg [W-1:0] flag_ff;
  reg [W-1:0] nxt_flag;

  always @* begin
    nxt_flag = flag_ff;
    if (restore) begin
      nxt_flag = {W{1'b0}};
    end
    nxt_flag = (nxt_flag & ~clr_in) | set_in;
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_ff <= {W{1'b0}};
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  assign flags = flag_ff;
endmodule // pgfi_w1c

// *** core/pgfi_regs.v ***
`timescale 1ns/1ps
`include "pgfi_regs.vh"
module pgfi_regs #(
  parameter RAILS = 4
) (
  // Clock and reset
  input wire sys_clk,
  input wire reset_n,
  // Register access port, one byte per access
  input wire reg_wr_en,
  input wire reg_rd_en,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  // Analog monitor levels, asynchronous
  input wire [RAILS-1:0] rail_valid,
  input wire thermal_warning_live,
  input wire thermal_shutdown_live,
  input wire overvoltage_live,
  input wire ext_clk_present,
  input wire supply_undervoltage,
  // Same-clock event sources
  input wire current_result_ready,
  input wire [7:0] ldo_event_register,
  input wire [7:0] buck_event_register,
  // Regulator and output requests
  input wire [RAILS-1:0] rail_enable_req,
  input wire gpo_a_req,
  input wire gpo_b_req,
  // Outputs to pins and regulators
  output reg power_good_out,
  output reg [RAILS-1:0] rail_enable,
  output reg general_output_a,
  output reg general_output_b,
  // Reset side effects
  output reg otp_reload,
  output reg serial_if_reset
);
  localparam NSYNC = RAILS + 5;

  // Synchronised levels
  wire [NSYNC-1:0] sync_level;
  wire [RAILS-1:0] valid_s;
  wire twarn_s;
  wire tsd_s;
  wire ovp_s;
  wire clk_s;
  wire uvlo_s;

  pgfi_sync #(
    .W(NSYNC)
  ) u_sync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .pin_in({supply_undervoltage, ext_clk_present, overvoltage_live,
             thermal_shutdown_live, thermal_warning_live, rail_valid}),
    .level_out(sync_level)
  );

  assign valid_s = sync_level[RAILS-1:0];
  assign twarn_s = sync_level[RAILS];
  assign tsd_s = sync_level[RAILS+1];
  assign ovp_s = sync_level[RAILS+2];
  assign clk_s = sync_level[RAILS+3];
  assign uvlo_s = sync_level[RAILS+4];

  // Previous levels for edge detection
  reg twarn_d_ff;
  reg tsd_d_ff;
  reg ovp_d_ff;
  reg clk_d_ff;
  reg uvlo_d_ff;

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      twarn_d_ff <= 1'b0;
      tsd_d_ff <= 1'b0;
      ovp_d_ff <= 1'b0;
      clk_d_ff <= 1'b0;
      uvlo_d_ff <= 1'b0;
    end else begin
      twarn_d_ff <= twarn_s;
      tsd_d_ff <= tsd_s;
      ovp_d_ff <= ovp_s;
      clk_d_ff <= clk_s;
      uvlo_d_ff <= uvlo_s;
    end
  end

  wire twarn_rise = twarn_s & ~twarn_d_ff;
  wire tsd_rise = tsd_s & ~tsd_d_ff;
  wire ovp_rise = ovp_s & ~ovp_d_ff;
  wire clk_change = clk_s ^ clk_d_ff;
  wire uvlo_rise = uvlo_s & ~uvlo_d_ff;

  // Access decode
  wire wr_ctrl_a = reg_wr_en && (reg_addr == `PGFI_ADDR_PG_CTRL_A);
  wire wr_ctrl_b = reg_wr_en && (reg_addr == `PGFI_ADDR_PG_CTRL_B);
  wire wr_fault = reg_wr_en && (reg_addr == `PGFI_ADDR_FAULT_LATCH);
  wire wr_reset = reg_wr_en && (reg_addr == `PGFI_ADDR_SOFT_RESET);
  wire wr_top = reg_wr_en && (reg_addr == `PGFI_ADDR_TOP_FLAGS);
  wire wr_top_b = reg_wr_en && (reg_addr == `PGFI_ADDR_TOP_FLAGS_B);

  // Soft reset sequencing
  reg soft_reset_cmd_ff;
  wire restore;

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      soft_reset_cmd_ff <= 1'b0;
    end else if (soft_reset_cmd_ff) begin
      soft_reset_cmd_ff <= 1'b0;
    end else if (wr_reset && reg_wdata[`PGFI_BIT_SOFT_RESET]) begin
      soft_reset_cmd_ff <= 1'b1;
    end
  end

  // Commanded reset or undervoltage brings every register except the reset-seen flag back to default
  assign restore = soft_reset_cmd_ff | uvlo_rise;

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      otp_reload <= 1'b0;
      serial_if_reset <= 1'b0;
    end else begin
      otp_reload <= restore;
      serial_if_reset <= soft_reset_cmd_ff;
    end
  end

  // Power-good control registers
  reg [7:0] pg_ctrl_a_ff;
  reg [7:0] pg_ctrl_b_ff;

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pg_ctrl_a_ff <= `PGFI_RST_PG_CTRL_A;
      pg_ctrl_b_ff <= `PGFI_RST_PG_CTRL_B;
    end else if (restore) begin
      pg_ctrl_a_ff <= `PGFI_RST_PG_CTRL_A;
      pg_ctrl_b_ff <= `PGFI_RST_PG_CTRL_B;
    end else begin
      if (wr_ctrl_a) begin
        pg_ctrl_a_ff <= reg_wdata;
      end
      if (wr_ctrl_b) begin
        pg_ctrl_b_ff <= reg_wdata;
      end
    end
  end

  wire pg_polarity = pg_ctrl_a_ff[`PGFI_BIT_POLARITY];
  wire [RAILS-1:0] mon_en = pg_ctrl_a_ff[`PGFI_MON_EN_MSB:`PGFI_MON_EN_LSB];
  wire thermal_warn_gates_pg = pg_ctrl_b_ff[`PGFI_BIT_TWARN_GATES];
  wire fault_latch_drives_pg = pg_ctrl_b_ff[`PGFI_BIT_FAULT_DRIVES];
  wire pg_operating_mode = pg_ctrl_b_ff[`PGFI_BIT_MODE];

  // Rail fault latches: bit 0 buck a, 1 buck b, 2 ldo a, 3 ldo b
  wire [RAILS-1:0] rail_fault;
  wire [RAILS-1:0] rail_bad = mon_en & ~valid_s;
  wire [RAILS-1:0] fault_clr = {RAILS{wr_fault}} & reg_wdata[RAILS-1:0] & valid_s;
  reg pg_ok_ff;

  pgfi_w1c #(
    .W(RAILS)
  ) u_fault (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .restore(restore),
    .set_in(rail_bad & {RAILS{pg_ok_ff}}),
    .clr_in(fault_clr),
    .flags(rail_fault)
  );

  wire ldo_b_fault_latch = rail_fault[3];
  wire ldo_a_fault_latch = rail_fault[2];
  wire buck_b_fault_latch = rail_fault[1];
  wire buck_a_fault_latch = rail_fault[0];
  wire any_fault = ldo_b_fault_latch | ldo_a_fault_latch | buck_b_fault_latch | buck_a_fault_latch;

  // Top flags
  wire [7:0] top_latched;
  wire thermal_shutdown_flag = top_latched[`PGFI_BIT_TSD];
  wire thermal_warning_flag = top_latched[`PGFI_BIT_TWARN];
  wire overvoltage_flag = top_latched[`PGFI_BIT_OVP];

  // Power-good qualification
  reg pg_ok;

  always @* begin
    if (fault_latch_drives_pg) begin
      pg_ok = ~any_fault;
    end else begin
      pg_ok = ~|rail_bad;
    end
    if (!pg_operating_mode && ((mon_en & ~rail_enable) != {RAILS{1'b0}})) begin
      pg_ok = 1'b0;
    end
    if (thermal_warn_gates_pg && thermal_warning_flag) begin
      pg_ok = 1'b0;
    end
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pg_ok_ff <= 1'b0;
      power_good_out <= 1'b0;
    end else begin
      pg_ok_ff <= pg_ok;
      power_good_out <= pg_ok ^ pg_polarity;
    end
  end

  wire pg_drop = pg_ok_ff & ~pg_ok;

  // Sticky top flags; summary bits are never cleared by software
  wire [7:0] top_set;
  wire [7:0] top_clr;

  assign top_set[`PGFI_BIT_PG_DROP] = pg_drop;
  assign top_set[`PGFI_BIT_LDO_SUM] = 1'b0;
  assign top_set[`PGFI_BIT_BUCK_SUM] = 1'b0;
  assign top_set[`PGFI_BIT_EXT_CLK] = clk_change;
  assign top_set[`PGFI_BIT_TSD] = tsd_rise;
  assign top_set[`PGFI_BIT_TWARN] = twarn_rise;
  assign top_set[`PGFI_BIT_OVP] = ovp_rise;
  assign top_set[`PGFI_BIT_CUR_RES] = current_result_ready;
  assign top_clr = {8{wr_top}} & reg_wdata & 8'h9f;

  pgfi_w1c #(
    .W(8)
  ) u_top (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .restore(restore),
    .set_in(top_set),
    .clr_in(top_clr),
    .flags(top_latched)
  );

  wire ldo_summary_flag = |ldo_event_register;
  wire buck_summary_flag = |buck_event_register;
  wire [7:0] top_view = {top_latched[7], ldo_summary_flag, buck_summary_flag, top_latched[4:0]};

  // Reset-seen flag survives the restore it reports
  wire reset_seen;

  pgfi_w1c #(
    .W(1)
  ) u_rst (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .restore(1'b0),
    .set_in(restore),
    .clr_in(wr_top_b & reg_wdata[`PGFI_BIT_RESET_SEEN]),
    .flags(reset_seen)
  );

  // Regulator and general output gating
  wire hard_block = thermal_shutdown_flag | tsd_s | overvoltage_flag | ovp_s;

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rail_enable <= {RAILS{1'b0}};
      general_output_a <= 1'b0;
      general_output_b <= 1'b0;
    end else if (hard_block) begin
      rail_enable <= {RAILS{1'b0}};
      general_output_a <= 1'b0;
      general_output_b <= 1'b0;
    end else begin
      rail_enable <= restore ? {RAILS{1'b0}} : rail_enable_req;
      general_output_a <= gpo_a_req;
      general_output_b <= gpo_b_req;
    end
  end

  // Read data, one cycle after the read strobe; unmapped reads give zero
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd_en) begin
      case (reg_addr)
        `PGFI_ADDR_PG_CTRL_A: reg_rdata <= pg_ctrl_a_ff;
        `PGFI_ADDR_PG_CTRL_B: reg_rdata <= pg_ctrl_b_ff;
        `PGFI_ADDR_FAULT_LATCH: reg_rdata <= {4'h0, rail_fault};
        `PGFI_ADDR_SOFT_RESET: reg_rdata <= {7'h00, soft_reset_cmd_ff};
        `PGFI_ADDR_TOP_FLAGS: reg_rdata <= top_view;
        `PGFI_ADDR_TOP_FLAGS_B: reg_rdata <= {7'h00, reset_seen};
        `PGFI_ADDR_BUCK_EVENTS: reg_rdata <= buck_event_register;
        `PGFI_ADDR_LDO_EVENTS: reg_rdata <= ldo_event_register;
        `PGFI_ADDR_TOP_STATUS: reg_rdata <= {pg_ok_ff, 2'b00, ~clk_s, tsd_s, twarn_s, ovp_s, 1'b0};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end
endmodule // pgfi_regs

// *** bench/pgfi_regs_asserts.sv ***
`timescale 1ns/1ps
module pgfi_regs_asserts #(
  parameter RAILS = 4
) (
  // Clock and reset
  input wire sys_clk,
  input wire reset_n,
  // Register port
  input wire reg_wr_en,
  input wire reg_rd_en,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  // Monitors and outputs
  input wire thermal_shutdown_live,
  input wire overvoltage_live,
  input wire [RAILS-1:0] rail_enable,
  input wire general_output_a,
  input wire general_output_b,
  input wire otp_reload,
  input wire serial_if_reset
);
  default clocking
    @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  wire outs_low = (rail_enable == '0) && !general_output_a && !general_output_b;
  // Shadow of the shutdown flag: set on the fifth high sample, as the sync chain and edge detect take four
  logic [2:0] tsd_run;
  logic tsd_seen;
  // Reserved bits of control b are writable, so they only read zero until written non-zero
  logic rsv_b_dirty;
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tsd_run <= 3'h0;
      tsd_seen <= 1'b0;
      rsv_b_dirty <= 1'b0;
    end else begin
      if (!thermal_shutdown_live) begin
        tsd_run <= 3'h0;
      end else if (tsd_run != 3'h7) begin
        tsd_run <= tsd_run + 3'h1;
      end
      if (thermal_shutdown_live && tsd_run == 3'h4) begin
        tsd_seen <= 1'b1;
      end else if ((reg_wr_en && reg_addr == 8'h19 && reg_wdata[3]) || otp_reload) begin
        tsd_seen <= 1'b0;
      end
      if (reg_wr_en && reg_addr == 8'h16) begin
        rsv_b_dirty <= |reg_wdata[7:3];
      end else if (otp_reload) begin
        rsv_b_dirty <= 1'b0;
      end
    end
  end
  sequence s_sr_wr;
    reg_wr_en && reg_addr == 8'h18 && reg_wdata[0];
  endsequence
  sequence s_tsd;
    thermal_shutdown_live [*7];
  endsequence
  sequence s_ovp;
    overvoltage_live [*7];
  endsequence
  property p_sr_pulse;
    s_sr_wr |-> ##[1:3] (otp_reload && serial_if_reset);
  endproperty
  a_sr_pulse: assert property (p_sr_pulse) else $error("soft reset gave no reload pulse");
  property p_sr_serial;
    serial_if_reset |-> otp_reload;
  endproperty
  a_sr_serial: assert property (p_sr_serial) else $error("serial reset without restore");
  property p_otp_once;
    otp_reload |=> !otp_reload;
  endproperty
  a_otp_once: assert property (p_otp_once) else $error("reload pulse too long");
  property p_sr_self;
    (reg_rd_en && reg_addr == 8'h18 && !$past(reg_wr_en)) |=> !reg_rdata[0];
  endproperty
  a_sr_self: assert property (p_sr_self) else $error("soft reset bit stuck");
  property p_rsv_b;
    (reg_rd_en && reg_addr == 8'h16 && !rsv_b_dirty) |=> reg_rdata[7:3] == 5'h00;
  endproperty
  a_rsv_b: assert property (p_rsv_b) else $error("control b reserved bits set");
  property p_tsd_low;
    s_tsd |-> outs_low;
  endproperty
  a_tsd_low: assert property (p_tsd_low) else $error("outputs live in shutdown");
  property p_ovp_low;
    s_ovp |-> outs_low;
  endproperty
  a_ovp_low: assert property (p_ovp_low) else $error("outputs live in overvoltage");
  property p_tsd_hold;
    tsd_seen |-> rail_enable == '0;
  endproperty
  a_tsd_hold: assert property (p_tsd_hold) else $error("rail enabled with shutdown flag");
endmodule // pgfi_regs_asserts
bind pgfi_regs pgfi_regs_asserts #(.RAILS(RAILS)) pgfi_regs_asserts_inst (
  .sys_clk(sys_clk), .reset_n(reset_n), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rail_enable(rail_enable),
  .thermal_shutdown_live(thermal_shutdown_live), .overvoltage_live(overvoltage_live),
  .general_output_a(general_output_a), .general_output_b(general_output_b),
  .otp_reload(otp_reload), .serial_if_reset(serial_if_reset));

// *** bench/pgfi_host.sv ***
`timescale 1ns/1ps
// Host side of the register port, one byte per access
module pgfi_host (
  // Clock
  input wire sys_clk,
  // Register port
  output logic reg_wr_en,
  output logic reg_rd_en,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire [7:0] reg_rdata
);
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  task wr(input [7:0] a, input [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge sys_clk);
    reg_wr_en = 1'b0;
    reg_wdata = ~d;
  endtask
  task rd(input [7:0] a, output [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge sys_clk);
    reg_rd_en = 1'b0;
    reg_addr = ~a;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask
endmodule // pgfi_host

// *** bench/power_good_fault_interrupt_regs_tb.sv ***
`timescale 1ns/1ps
module power_good_fault_interrupt_regs_tb;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] rail_valid = 4'h0;
  logic thermal_warning_live = 1'b0;
  logic thermal_shutdown_live = 1'b0;
  logic overvoltage_live = 1'b0;
  logic ext_clk_present = 1'b0;
  logic supply_undervoltage = 1'b0;
  logic current_result_ready = 1'b0;
  logic [7:0] ldo_event_register = 8'h00;
  logic [7:0] buck_event_register = 8'h00;
  logic [3:0] rail_enable_req = 4'h0;
  logic gpo_req = 1'b1;
  wire reg_wr_en;
  wire reg_rd_en;
  wire [7:0] reg_addr;
  wire [7:0] reg_wdata;
  wire [7:0] reg_rdata;
  wire power_good_out;
  wire [3:0] rail_enable;
  wire general_output_a;
  wire general_output_b;
  int bad_count = 0;
  int checked = 0;
  logic [7:0] got;
  always #2 sys_clk = ~sys_clk;
  pgfi_host pgfi_host_inst (.sys_clk(sys_clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  pgfi_regs pgfi_regs_inst (.sys_clk(sys_clk), .reset_n(reset_n), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .rail_valid(rail_valid), .thermal_warning_live(thermal_warning_live),
    .thermal_shutdown_live(thermal_shutdown_live), .overvoltage_live(overvoltage_live),
    .ext_clk_present(ext_clk_present), .supply_undervoltage(supply_undervoltage),
    .current_result_ready(current_result_ready), .ldo_event_register(ldo_event_register),
    .buck_event_register(buck_event_register), .rail_enable_req(rail_enable_req),
    .gpo_a_req(gpo_req), .gpo_b_req(gpo_req), .power_good_out(power_good_out),
    .rail_enable(rail_enable), .general_output_a(general_output_a),
    .general_output_b(general_output_b), .otp_reload(), .serial_if_reset());
  task chk(input string what, input [7:0] exp, input [7:0] seen);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task wr(input [7:0] a, input [7:0] d);
    pgfi_host_inst.wr(a, d);
  endtask
  task rdc(input [7:0] a, input [7:0] exp);
    pgfi_host_inst.rd(a, got);
    chk($sformatf("register %h", a), exp, got);
  endtask
  task pg(input logic e);
    chk("power_good_out", {7'h0, e}, {7'h0, power_good_out});
  endtask
  task outs(input [7:0] exp);
    chk("regulator outputs", exp, {2'h0, general_output_a, general_output_b, rail_enable});
  endtask
  task give_verdict;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    cyc(2);
    reset_n = 1'b1;
    cyc(8);
    pg(1'b0);
    rdc(8'h16, 8'h00);
    rdc(8'h17, 8'h00);
    rdc(8'h18, 8'h00);
    rdc(8'h19, 8'h00);
    rail_enable_req = 4'hf;
    rail_valid = 4'hf;
    cyc(8);
    pg(1'b1);
    wr(8'h15, 8'h8f);
    cyc(2);
    pg(1'b0);
    wr(8'h15, 8'h0f);
    rail_enable_req = 4'h0;
    cyc(4);
    pg(1'b0);
    wr(8'h16, 8'h01);
    cyc(4);
    pg(1'b1);
    rail_enable_req = 4'hf;
    wr(8'h16, 8'h02);
    rail_valid = 4'hb;
    cyc(8);
    pg(1'b0);
    rdc(8'h17, 8'h04);
    rdc(8'h19, 8'h80);
    wr(8'h17, 8'h0c);
    rdc(8'h17, 8'h04);
    rail_valid = 4'hf;
    cyc(8);
    pg(1'b0);
    wr(8'h17, 8'h04);
    cyc(4);
    pg(1'b1);
    wr(8'h19, 8'h80);
    rdc(8'h19, 8'h00);
    wr(8'h16, 8'h04);
    thermal_warning_live = 1'b1;
    cyc(8);
    pg(1'b0);
    rdc(8'h1d, 8'h14);
    thermal_warning_live = 1'b0;
    cyc(8);
    rdc(8'h19, 8'h84);
    pg(1'b0);
    wr(8'h19, 8'h84);
    cyc(4);
    pg(1'b1);
    current_result_ready = 1'b1;
    cyc(1);
    current_result_ready = 1'b0;
    ext_clk_present = 1'b1;
    cyc(8);
    rdc(8'h19, 8'h11);
    wr(8'h19, 8'h00);
    rdc(8'h19, 8'h11);
    wr(8'h19, 8'h11);
    ext_clk_present = 1'b0;
    cyc(8);
    rdc(8'h19, 8'h10);
    wr(8'h19, 8'h10);
    ldo_event_register = 8'h44;
    buck_event_register = 8'h01;
    wr(8'h19, 8'h60);
    rdc(8'h19, 8'h60);
    rdc(8'h1c, 8'h44);
    ldo_event_register = 8'h00;
    rdc(8'h19, 8'h20);
    buck_event_register = 8'h00;
    rdc(8'h19, 8'h00);
    wr(8'h16, 8'h01);
    overvoltage_live = 1'b1;
    cyc(8);
    outs(8'h00);
    overvoltage_live = 1'b0;
    cyc(8);
    rdc(8'h19, 8'h02);
    wr(8'h19, 8'h02);
    cyc(2);
    outs(8'h3f);
    thermal_shutdown_live = 1'b1;
    cyc(8);
    outs(8'h00);
    thermal_shutdown_live = 1'b0;
    cyc(8);
    outs(8'h00);
    rdc(8'h19, 8'h08);
    wr(8'h18, 8'h01);
    cyc(2);
    rdc(8'h18, 8'h00);
    rdc(8'h16, 8'h00);
    // Restore selects gated mode while the shutdown flag still holds the enables low, so the pin falls once
    rdc(8'h19, 8'h80);
    rdc(8'h1a, 8'h01);
    wr(8'h1a, 8'h01);
    rdc(8'h1a, 8'h00);
    wr(8'h16, 8'h04);
    supply_undervoltage = 1'b1;
    cyc(8);
    rdc(8'h1a, 8'h01);
    rdc(8'h16, 8'h00);
    supply_undervoltage = 1'b0;
    cyc(8);
    rdc(8'h1a, 8'h01);
    wr(8'h1a, 8'h01);
    rdc(8'h30, 8'h00);
    give_verdict;
  end
endmodule // power_good_fault_interrupt_regs_tb
